/* File: rtl/swdt_pkg.sv */
// Constants and helpers of the system watchdog timer
// Assumes a 32-bit AXI4-Lite register bus with byte addresses
package swdt_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W = 18;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_OPT1 = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_OPT2 = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_SRS = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_ISTS = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_IMSK = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_CNT = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_LOCK = 8'h18;
	// Field positions
	localparam int EN_BIT = 0;
	localparam int TO_BIT = 1;
	localparam int CS_BIT = 0;
	localparam int SRC_BIT = 0;
	localparam int IRQ_W = 2;
	// Reset values of the option fields
	localparam logic EN_RST = 1'h1;
	localparam logic TO_RST = 1'h1;
	localparam logic CS_RST = 1'h0;
	// Terminal counts, overflow count minus one
	localparam logic [CNT_W-1:0] TERM_SLOW_SHORT = 18'h0_03FF;
	localparam logic [CNT_W-1:0] TERM_SLOW_LONG = 18'h0_1FFF;
	localparam logic [CNT_W-1:0] TERM_BUS_SHORT = 18'h0_1FFF;
	localparam logic [CNT_W-1:0] TERM_BUS_LONG = 18'h3_FFFF;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Overflow reset sequence
	typedef enum logic [1:0] {
		ST_RUN = 2'h0,
		ST_REQ = 2'h1,
		ST_RESTART = 2'h3
	} swdt_state_t;
	// Terminal count from clock and time-out selects
	function automatic logic [CNT_W-1:0] swdt_term(input logic cs, input logic to);
		if (cs) begin
			return to ? TERM_BUS_LONG : TERM_BUS_SHORT;
		end
		return to ? TERM_SLOW_LONG : TERM_SLOW_SHORT;
	endfunction
	// Address decode shared by reads and writes
	function automatic logic swdt_mapped(input logic [ADDR_W-1:0] a);
		return (a == OFS_OPT1) || (a == OFS_OPT2) || (a == OFS_SRS) ||
			(a == OFS_ISTS) || (a == OFS_IMSK) || (a == OFS_CNT) || (a == OFS_LOCK);
	endfunction
endpackage

/* File: rtl/swdt_reg_if.sv */
// Register access strobes between bus slave and watchdog core
// Assumes both ends on the same clock
`timescale 1ns/1ps
interface swdt_reg_if;
	logic                         wr_en;   // One-cycle write
	logic [swdt_pkg::ADDR_W-1:0]  wr_addr; // Write address
	logic [swdt_pkg::DATA_W-1:0]  wr_data; // Write data
	logic [3:0]                   wr_strb; // Byte enables
	logic                         wr_err;  // Unmapped write
	logic                         rd_en;   // One-cycle read
	logic [swdt_pkg::ADDR_W-1:0]  rd_addr; // Read address
	logic [swdt_pkg::DATA_W-1:0]  rd_data; // Read data
	logic                         rd_err;  // Unmapped read
	modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		input wr_err, rd_data, rd_err);
	modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		output wr_err, rd_data, rd_err);
endinterface

/* File: rtl/swdt_axil_slave.sv */
// AXI4-Lite slave turning bus traffic into register strobes
// Assumes one write and one read in flight at most
`timescale 1ns/1ps
module swdt_axil_slave
	import swdt_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire logic [ADDR_W-1:0]   s_awaddr,
	input  wire logic                s_awvalid,
	output logic                     s_awready,
	input  wire logic [DATA_W-1:0]   s_wdata,
	input  wire logic [3:0]          s_wstrb,
	input  wire logic                s_wvalid,
	output logic                     s_wready,
	output logic [1:0]               s_bresp,
	output logic                     s_bvalid,
	input  wire logic                s_bready,
	input  wire logic [ADDR_W-1:0]   s_araddr,
	input  wire logic                s_arvalid,
	output logic                     s_arready,
	output logic [DATA_W-1:0]        s_rdata,
	output logic [1:0]               s_rresp,
	output logic                     s_rvalid,
	input  wire logic                s_rready,
	swdt_reg_if.bus                  rif
);
	logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, awr_q, awr_d, wr_q, wr_d;
	logic arr_q, arr_d, rv_q, rv_d, fire;
	logic [ADDR_W-1:0] awa_q, awa_d;
	logic [DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
	logic [3:0] ws_q, ws_d;
	logic [1:0] br_q, br_d, rr_q, rr_d;
	////////////////////////////////////////
	// Both halves held, write goes out
	assign fire = aw_q & w_q;
	assign rif.wr_en = fire;
	assign rif.wr_addr = awa_q;
	assign rif.wr_data = wd_q;
	assign rif.wr_strb = ws_q;
	assign rif.rd_en = s_arvalid & arr_q;
	assign rif.rd_addr = s_araddr;
	// Next state of both channels
	always_comb begin
		aw_d = aw_q; w_d = w_q; awa_d = awa_q; wd_d = wd_q; ws_d = ws_q;
		bv_d = bv_q; br_d = br_q; rv_d = rv_q; rd_d = rd_q; rr_d = rr_q;
		if (s_awvalid & awr_q) begin
			aw_d = 1'b1;
			awa_d = s_awaddr;
		end
		if (s_wvalid & wr_q) begin
			w_d = 1'b1;
			wd_d = s_wdata;
			ws_d = s_wstrb;
		end
		if (bv_q & s_bready) begin
			bv_d = 1'b0;
		end
		if (fire) begin
			aw_d = 1'b0;
			w_d = 1'b0;
			bv_d = 1'b1;
			br_d = rif.wr_err ? RESP_SLVERR : RESP_OKAY;
		end
		if (rv_q & s_rready) begin
			rv_d = 1'b0;
		end
		if (rif.rd_en) begin
			rv_d = 1'b1;
			rd_d = rif.rd_data;
			rr_d = rif.rd_err ? RESP_SLVERR : RESP_OKAY;
		end
		awr_d = ~aw_d & ~bv_d & ~fire;
		wr_d = ~w_d & ~bv_d & ~fire;
		arr_d = ~rv_d;
	end
	// Registers only
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b0; rv_q <= 1'b0;
			awr_q <= 1'b1; wr_q <= 1'b1; arr_q <= 1'b1;
			awa_q <= '0; wd_q <= '0; ws_q <= '0; rd_q <= '0;
			br_q <= RESP_OKAY; rr_q <= RESP_OKAY;
		end else begin
			aw_q <= aw_d; w_q <= w_d; bv_q <= bv_d; rv_q <= rv_d;
			awr_q <= awr_d; wr_q <= wr_d; arr_q <= arr_d;
			awa_q <= awa_d; wd_q <= wd_d; ws_q <= ws_d; rd_q <= rd_d;
			br_q <= br_d; rr_q <= rr_d;
		end
	end
	assign s_awready = awr_q;
	assign s_wready = wr_q;
	assign s_bvalid = bv_q;
	assign s_bresp = br_q;
	assign s_arready = arr_q;
	assign s_rvalid = rv_q;
	assign s_rdata = rd_q;
	assign s_rresp = rr_q;
endmodule

/* File: rtl/swdt_counter.sv */
// Watchdog up-counter with terminal-count overflow pulse
// Assumes tick, clear and freeze are on the same clock
`timescale 1ns/1ps
module swdt_counter
	import swdt_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              tick,
	input  wire logic              clear,
	input  wire logic              freeze,
	input  wire logic [CNT_W-1:0]  term,
	output logic [CNT_W-1:0]       count,
	output logic                   ovf
);
	logic [CNT_W-1:0] cnt_q, cnt_d; // Count value
	logic             ovf_q, ovf_d; // Overflow pulse
	////////////////////////////////////////
	// Clear first, then hold, then count
	always_comb begin
		cnt_d = cnt_q;
		ovf_d = 1'b0;
		if (clear) begin
			cnt_d = '0;
		end else if (tick & ~freeze) begin
			if (cnt_q >= term) begin
				cnt_d = '0;
				ovf_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 18'h0_0001;
			end
		end
	end
	// Registers only
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_q <= '0;
			ovf_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			ovf_q <= ovf_d;
		end
	end
	assign count = cnt_q;
	assign ovf = ovf_q;
	////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	property p_ovf_term;
		ovf_q |-> ($past(cnt_q) == $past(term)) && (cnt_q == '0);
	endproperty
	a_ovf_term: assert property (p_ovf_term) else $error("overflow off terminal");
	property p_bus_long;
		ovf_q && $past(term) == TERM_BUS_LONG |-> $past(cnt_q) == 18'h3_FFFF;
	endproperty
	a_bus_long: assert property (p_bus_long) else $error("bus long count wrong");
endmodule

/* File: rtl/swdt_top.sv */
// System watchdog timer core with AXI4-Lite registers
// Assumes slow clock, debug and stop arrive as asynchronous pins
// Assumes the system acts on WDT_RESET_REQ; RESET is power-on only
//
// What this block does
// - Unserviced overflow while enabled requests system reset
// - Every reset sets enable; clearing disables
// - Any write to status address clears counter
// - Clock select: 0 slow source, 1 bus
// - Slow clock: 2^10 or 2^13 cycles
// - Bus clock: 2^13 or 2^18 cycles
// - Default is slow clock, long time-out
// - Both option registers accept one write only
// - First option write also clears counter
// - Debug mode freezes the counter
// - Bus clock: counter holds during stop
// - Slow clock: stop clears counter to zero
// - Overflow reset sets its source status bit
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module swdt_top
	import swdt_pkg::*;
(
	input  wire logic                        CLK,
	input  wire logic                        RESET,
	input  wire logic [swdt_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic                        S_AXI_AWVALID,
	output logic                             S_AXI_AWREADY,
	input  wire logic [swdt_pkg::DATA_W-1:0] S_AXI_WDATA,
	input  wire logic [3:0]                  S_AXI_WSTRB,
	input  wire logic                        S_AXI_WVALID,
	output logic                             S_AXI_WREADY,
	output logic [1:0]                       S_AXI_BRESP,
	output logic                             S_AXI_BVALID,
	input  wire logic                        S_AXI_BREADY,
	input  wire logic [swdt_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic                        S_AXI_ARVALID,
	output logic                             S_AXI_ARREADY,
	output logic [swdt_pkg::DATA_W-1:0]      S_AXI_RDATA,
	output logic [1:0]                       S_AXI_RRESP,
	output logic                             S_AXI_RVALID,
	input  wire logic                        S_AXI_RREADY,
	input  wire logic                        SLOW_CLK_IN,
	input  wire logic                        DEBUG_MODE_IN,
	input  wire logic                        STOP_MODE_IN,
	output logic                             WDT_RESET_REQ,
	output logic                             IRQ
);
	import swdt_pkg::*;

	////////////////////////////////////////
	// Declarations
	swdt_reg_if rif ();
	logic slow_m_q, slow_s_q, slow_p_q; // Slow source sync
	logic dbg_m_q, dbg_s_q;             // Debug sync
	logic stop_m_q, stop_s_q;           // Stop sync
	logic en_q, en_d;                   // Watchdog enable
	logic to_q, to_d;                   // Time-out select
	logic cs_q, cs_d;                   // Clock select
	logic lk1_q, lk1_d;                 // Options one locked
	logic lk2_q, lk2_d;                 // Options two locked
	logic src_q, src_d;                 // Watchdog reset source
	logic [IRQ_W-1:0] sts_q, sts_d;     // Sticky events
	logic [IRQ_W-1:0] msk_q, msk_d;     // Event mask
	logic irq_q, irq_d;                 // Interrupt output
	logic req_q, req_d;                 // Reset request output
	swdt_state_t st_q, st_d;            // Reset sequence
	logic [IRQ_W-1:0] ev;               // Events this cycle
	logic [IRQ_W-1:0] clr;              // Software clears
	logic slow_edge;                    // Slow source rising
	logic tick;                         // Counter clock tick
	logic cnt_clear;                    // Counter clear
	logic freeze;                       // Counter hold
	logic svc;                          // Service write
	logic first;                        // First option write
	logic wr_o1, wr_o2, b0;             // Option write decode
	logic lock_evt;                     // Write to locked options
	logic ovf;                          // Counter overflow
	logic [CNT_W-1:0] cnt;              // Counter value
	logic [CNT_W-1:0] term;             // Selected terminal

	////////////////////////////////////////
	// Bus slave
	swdt_axil_slave u_bus (
		.clk       (CLK),
		.reset     (RESET),
		.s_awaddr  (S_AXI_AWADDR),
		.s_awvalid (S_AXI_AWVALID),
		.s_awready (S_AXI_AWREADY),
		.s_wdata   (S_AXI_WDATA),
		.s_wstrb   (S_AXI_WSTRB),
		.s_wvalid  (S_AXI_WVALID),
		.s_wready  (S_AXI_WREADY),
		.s_bresp   (S_AXI_BRESP),
		.s_bvalid  (S_AXI_BVALID),
		.s_bready  (S_AXI_BREADY),
		.s_araddr  (S_AXI_ARADDR),
		.s_arvalid (S_AXI_ARVALID),
		.s_arready (S_AXI_ARREADY),
		.s_rdata   (S_AXI_RDATA),
		.s_rresp   (S_AXI_RRESP),
		.s_rvalid  (S_AXI_RVALID),
		.s_rready  (S_AXI_RREADY),
		.rif       (rif.bus)
	);

	////////////////////////////////////////
	// Pin synchronisers, first stage read by second only
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			slow_m_q <= 1'b0;
			slow_s_q <= 1'b0;
			slow_p_q <= 1'b0;
			dbg_m_q <= 1'b0;
			dbg_s_q <= 1'b0;
			stop_m_q <= 1'b0;
			stop_s_q <= 1'b0;
		end else begin
			slow_m_q <= SLOW_CLK_IN;
			slow_s_q <= slow_m_q;
			slow_p_q <= slow_s_q;
			dbg_m_q <= DEBUG_MODE_IN;
			dbg_s_q <= dbg_m_q;
			stop_m_q <= STOP_MODE_IN;
			stop_s_q <= stop_m_q;
		end
	end

	////////////////////////////////////////
	// Counter clocking and control
	assign slow_edge = slow_s_q & ~slow_p_q;
	// Bus clock ticks every cycle
	assign tick = cs_q | slow_edge;
	assign term = swdt_term(cs_q, to_q);
	// Debug, or stop with bus clock, holds the count
	assign freeze = dbg_s_q | (stop_s_q & cs_q);
	// Write decode
	assign b0 = rif.wr_strb[0];
	assign wr_o1 = rif.wr_en & (rif.wr_addr == OFS_OPT1) & b0;
	assign wr_o2 = rif.wr_en & (rif.wr_addr == OFS_OPT2) & b0;
	// Any write to the status address services
	assign svc = rif.wr_en & (rif.wr_addr == OFS_SRS);
	assign first = (wr_o1 & ~lk1_q) | (wr_o2 & ~lk2_q);
	assign lock_evt = (wr_o1 & lk1_q) | (wr_o2 & lk2_q);
	// Clear sources; disabled or resetting keeps zero
	always_comb begin
		cnt_clear = svc | first;
		if (stop_s_q & ~cs_q) begin
			cnt_clear = 1'b1;
		end
		if (~en_q | (st_q != ST_RUN)) begin
			cnt_clear = 1'b1;
		end
	end

	swdt_counter u_cnt (
		.clk    (CLK),
		.reset  (RESET),
		.tick   (tick),
		.clear  (cnt_clear),
		.freeze (freeze),
		.term   (term),
		.count  (cnt),
		.ovf    (ovf)
	);

	////////////////////////////////////////
	// Options, sequence and interrupt next state
	always_comb begin
		en_d = en_q;
		to_d = to_q;
		cs_d = cs_q;
		lk1_d = lk1_q;
		lk2_d = lk2_q;
		src_d = src_q;
		st_d = st_q;
		msk_d = msk_q;
		// Write-once option registers
		if (wr_o1 & ~lk1_q) begin
			en_d = rif.wr_data[EN_BIT];
			to_d = rif.wr_data[TO_BIT];
			lk1_d = 1'b1;
		end
		if (wr_o2 & ~lk2_q) begin
			cs_d = rif.wr_data[CS_BIT];
			lk2_d = 1'b1;
		end
		// Mask write
		if (rif.wr_en & (rif.wr_addr == OFS_IMSK) & b0) begin
			msk_d = rif.wr_data[IRQ_W-1:0];
		end
		// Overflow reset sequence
		unique case (st_q)
			ST_RUN: begin
				if (ovf) begin
					st_d = ST_REQ;
				end
			end
			ST_REQ: begin
				// Hold for at least one counter tick
				if (tick) begin
					st_d = ST_RESTART;
				end
			end
			ST_RESTART: begin
				// Internal reset restores defaults and unlocks
				en_d = EN_RST;
				to_d = TO_RST;
				cs_d = CS_RST;
				lk1_d = 1'b0;
				lk2_d = 1'b0;
				src_d = 1'b1;
				st_d = ST_RUN;
			end
			default: begin
				st_d = ST_RUN;
			end
		endcase
		req_d = (st_d == ST_REQ);
		// Sticky events, set wins over clear
		ev = {lock_evt, ovf};
		clr = '0;
		if (rif.wr_en & (rif.wr_addr == OFS_ISTS) & b0) begin
			clr = rif.wr_data[IRQ_W-1:0];
		end
		sts_d = (sts_q & ~clr) | ev;
		irq_d = |(sts_d & msk_d);
	end

	// Registers only
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			en_q <= EN_RST;
			to_q <= TO_RST;
			cs_q <= CS_RST;
			lk1_q <= 1'b0;
			lk2_q <= 1'b0;
			src_q <= 1'b0;
			st_q <= ST_RUN;
			msk_q <= '0;
			sts_q <= '0;
			irq_q <= 1'b0;
			req_q <= 1'b0;
		end else begin
			en_q <= en_d;
			to_q <= to_d;
			cs_q <= cs_d;
			lk1_q <= lk1_d;
			lk2_q <= lk2_d;
			src_q <= src_d;
			st_q <= st_d;
			msk_q <= msk_d;
			sts_q <= sts_d;
			irq_q <= irq_d;
			req_q <= req_d;
		end
	end
	assign WDT_RESET_REQ = req_q;
	assign IRQ = irq_q;

	////////////////////////////////////////
	// Register read mux and decode answers
	assign rif.wr_err = ~swdt_mapped(rif.wr_addr);
	always_comb begin
		rif.rd_data = '0;
		rif.rd_err = ~swdt_mapped(rif.rd_addr);
		unique case (rif.rd_addr)
			OFS_OPT1: begin
				rif.rd_data[EN_BIT] = en_q;
				rif.rd_data[TO_BIT] = to_q;
			end
			OFS_OPT2: rif.rd_data[CS_BIT] = cs_q;
			OFS_SRS:  rif.rd_data[SRC_BIT] = src_q;
			OFS_ISTS: rif.rd_data[IRQ_W-1:0] = sts_q;
			OFS_IMSK: rif.rd_data[IRQ_W-1:0] = msk_q;
			OFS_CNT:  rif.rd_data[CNT_W-1:0] = cnt;
			OFS_LOCK: rif.rd_data[1:0] = {lk2_q, lk1_q};
			default:  rif.rd_data = '0;
		endcase
	end

	////////////////////////////////////////
	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	sequence s_hold;
		WDT_RESET_REQ && !tick;
	endsequence
	sequence s_release;
		WDT_RESET_REQ && tick;
	endsequence
	property p_ovf_req;
		ovf |=> WDT_RESET_REQ;
	endproperty
	a_ovf_req: assert property (p_ovf_req) else $error("no request on overflow");
	property p_restart_en;
		st_q == ST_RESTART |=> en_q && !lk1_q && !lk2_q;
	endproperty
	a_restart_en: assert property (p_restart_en) else $error("enable not set");
	property p_service;
		svc && st_q == ST_RUN |=> cnt == '0 && $stable(src_q);
	endproperty
	a_service: assert property (p_service) else $error("service failed");
	property p_bus_tick;
		cs_q && en_q && st_q == ST_RUN && !freeze && !cnt_clear && cnt < term
			|=> cnt == $past(cnt) + 18'h0_0001;
	endproperty
	a_bus_tick: assert property (p_bus_tick) else $error("bus clock not counting");
	property p_default;
		st_q == ST_RESTART |=> term == TERM_SLOW_LONG;
	endproperty
	a_default: assert property (p_default) else $error("wrong default");
	property p_locked;
		wr_o1 && lk1_q && st_q == ST_RUN |=> $stable(en_q) && $stable(to_q);
	endproperty
	a_locked: assert property (p_locked) else $error("locked write took");
	property p_first;
		first && st_q == ST_RUN |=> cnt == '0 && (lk1_q || lk2_q);
	endproperty
	a_first: assert property (p_first) else $error("first write no clear");
	property p_debug;
		dbg_s_q && !cnt_clear |=> $stable(cnt);
	endproperty
	a_debug: assert property (p_debug) else $error("count moved in debug");
	property p_stop_bus;
		stop_s_q && cs_q && !cnt_clear |=> $stable(cnt);
	endproperty
	a_stop_bus: assert property (p_stop_bus) else $error("count moved in stop");
	property p_stop_slow;
		stop_s_q && !cs_q |=> cnt == '0;
	endproperty
	a_stop_slow: assert property (p_stop_slow) else $error("stop no clear");
	property p_src;
		st_q == ST_RESTART |=> src_q;
	endproperty
	a_src: assert property (p_src) else $error("source bit not set");
	property p_hold;
		s_hold |=> WDT_RESET_REQ && cnt == '0;
	endproperty
	a_hold: assert property (p_hold) else $error("request dropped early");
	property p_release;
		s_release |=> (st_q == ST_RESTART && !WDT_RESET_REQ) ##1 (cnt == '0);
	endproperty
	a_release: assert property (p_release) else $error("bad restart");
endmodule

/* File: testbench/system_watchdog_timer_bench.sv */
// Self-checking bench for the system watchdog timer top
// Assumes package, interface and design modules are compiled first
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module system_watchdog_timer_bench;
	import swdt_pkg::*;
	////////////////////////////////////////////////////////////////////
	logic              clk = 0;       // Bus clock
	logic              reset = 1;     // Power-on reset
	logic [ADDR_W-1:0] awaddr = 0;    // Write address
	logic [ADDR_W-1:0] araddr = 0;    // Read address
	logic [DATA_W-1:0] wdata = 0;     // Write data
	logic [DATA_W-1:0] rdata;         // Read data pin
	logic [DATA_W-1:0] rd_q;          // Last read word
	logic [3:0]        wstrb = 0;     // Byte enables
	logic              awvalid = 0;   // Master valids and readies
	logic              wvalid = 0;
	logic              bready = 0;
	logic              arvalid = 0;
	logic              rready = 0;
	logic              awready;       // Slave answers
	logic              wready;
	logic              bvalid;
	logic              arready;
	logic              rvalid;
	logic [1:0]        bresp;
	logic [1:0]        rresp;
	logic [1:0]        rresp_q;       // Last read response
	logic [1:0]        bresp_q;       // Last write response
	logic              slow = 0;      // Slow source pin
	logic              dbg = 0;       // Debug mode pin
	logic              stop = 0;      // Stop mode pin
	logic              req;           // Watchdog reset request
	logic              irq;           // Interrupt line
	int                n_fail = 0;
	int                samples_checked = 0;
	int                n;             // Cycle count to overflow
	// Bus clock, 5 ns period
	always #2.5 clk = ~clk;
	swdt_top uut (
		.CLK           (clk),
		.RESET         (reset),
		.S_AXI_AWADDR  (awaddr),
		.S_AXI_AWVALID (awvalid),
		.S_AXI_AWREADY (awready),
		.S_AXI_WDATA   (wdata),
		.S_AXI_WSTRB   (wstrb),
		.S_AXI_WVALID  (wvalid),
		.S_AXI_WREADY  (wready),
		.S_AXI_BRESP   (bresp),
		.S_AXI_BVALID  (bvalid),
		.S_AXI_BREADY  (bready),
		.S_AXI_ARADDR  (araddr),
		.S_AXI_ARVALID (arvalid),
		.S_AXI_ARREADY (arready),
		.S_AXI_RDATA   (rdata),
		.S_AXI_RRESP   (rresp),
		.S_AXI_RVALID  (rvalid),
		.S_AXI_RREADY  (rready),
		.SLOW_CLK_IN   (slow),
		.DEBUG_MODE_IN (dbg),
		.STOP_MODE_IN  (stop),
		.WDT_RESET_REQ (req),
		.IRQ           (irq)
	);
	////////////////////////////////////////////////////////////////////
	// Write one word; readies sampled at the low phase, released after edge
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic aw_t;
		logic w_t;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			aw_t = awvalid & awready;
			w_t = wvalid & wready;
			@(posedge clk);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
		end while (awvalid | wvalid);
		do @(negedge clk); while (!bvalid);
		bresp_q = bresp;
		@(posedge clk);
		bready <= 1'b0;
	endtask
	// Read one word into rd_q and rresp_q
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge clk); while (!arready);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (!rvalid);
		rd_q = rdata;
		rresp_q = rresp;
		@(posedge clk);
		rready <= 1'b0;
	endtask
	// Read and compare
	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		rd(a);
		`CHK(rd_q, e)
	endtask
	// Slow source edges, 8 bus cycles each, long enough for the synchroniser
	task automatic tick(input int k);
		repeat (2 * k) begin
			repeat (4) @(posedge clk);
			slow <= ~slow;
		end
	endtask
	////////////////////////////////////////////////////////////////////
	// Reset values and unmapped access
	task automatic t_reset;
		rchk(OFS_OPT1, 32'h0000_0003);
		rchk(OFS_OPT2, 32'h0000_0000);
		rchk(OFS_SRS, 32'h0000_0000);
		rchk(OFS_LOCK, 32'h0000_0000);
		rd(8'h40);
		`CHK(rresp_q, RESP_SLVERR)
		// Unmapped write answers with an error and changes nothing
		wr(8'h40, 32'hFFFF_FFFF);
		`CHK(bresp_q, RESP_SLVERR)
		$display("reset test done");
	endtask
	// Servicing from main flow clears the count, status untouched
	task automatic t_service;
		tick(20);
		rchk(OFS_CNT, 32'h0000_0014);
		wr(OFS_SRS, 32'hFFFF_FFFF);
		`CHK(bresp_q, RESP_OKAY)
		rchk(OFS_CNT, 32'h0000_0000);
		rchk(OFS_SRS, 32'h0000_0000);
		$display("service test done");
	endtask
	// Debug freeze, then stop clears with slow source
	task automatic t_modes;
		dbg <= 1'b1;
		tick(6);
		rchk(OFS_CNT, 32'h0000_0000);
		dbg <= 1'b0;
		tick(3);
		rchk(OFS_CNT, 32'h0000_0003);
		stop <= 1'b1;
		tick(2);
		rchk(OFS_CNT, 32'h0000_0000);
		stop <= 1'b0;
		tick(5);
		rchk(OFS_CNT, 32'h0000_0005);
		$display("mode test done");
	endtask
	// Write-once options and lock violation flag
	task automatic t_lock;
		wr(OFS_OPT1, 32'h0000_0001);
		rchk(OFS_CNT, 32'h0000_0000);
		wr(OFS_OPT2, 32'h0000_0000);
		rchk(OFS_LOCK, 32'h0000_0003);
		wr(OFS_OPT1, 32'h0000_0000);
		`CHK(bresp_q, RESP_OKAY)
		rchk(OFS_OPT1, 32'h0000_0001);
		rchk(OFS_ISTS, 32'h0000_0002);
		wr(OFS_ISTS, 32'h0000_0002);
		rchk(OFS_ISTS, 32'h0000_0000);
		$display("lock test done");
	endtask
	// Short slow overflow, interrupt, restart with defaults
	task automatic t_ovf;
		wr(OFS_IMSK, 32'h0000_0001);
		wr(OFS_SRS, 32'h0000_0000);
		tick(1023);
		rchk(OFS_CNT, 32'h0000_03FF);
		`CHK(req, 1'b0)
		tick(1);
		repeat (4) @(posedge clk);
		@(negedge clk);
		`CHK(req, 1'b1)
		`CHK(irq, 1'b1)
		wr(OFS_IMSK, 32'h0000_0000);
		@(negedge clk);
		`CHK(irq, 1'b0)
		`CHK(req, 1'b1)
		tick(1);
		@(negedge clk);
		`CHK(req, 1'b0)
		rchk(OFS_SRS, 32'h0000_0001);
		rchk(OFS_OPT1, 32'h0000_0003);
		rchk(OFS_LOCK, 32'h0000_0000);
		wr(OFS_ISTS, 32'h0000_0001);
		rchk(OFS_ISTS, 32'h0000_0000);
		$display("overflow test done");
	endtask
	// Bus clock: stop holds, short count, then disable
	task automatic t_bus;
		wr(OFS_OPT2, 32'h0000_0001);
		wr(OFS_OPT1, 32'h0000_0001);
		stop <= 1'b1;
		repeat (20) @(posedge clk);
		rd(OFS_CNT);
		repeat (20) @(posedge clk);
		rchk(OFS_CNT, rd_q);
		stop <= 1'b0;
		wr(OFS_SRS, 32'h0000_0000);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (req !== 1'b1);
		`CHK((n >= 8180) && (n <= 8200), 1'b1)
		repeat (4) @(posedge clk);
		wr(OFS_OPT1, 32'h0000_0000);
		wr(OFS_OPT2, 32'h0000_0001);
		repeat (9000) @(posedge clk);
		@(negedge clk);
		`CHK(req, 1'b0)
		rchk(OFS_CNT, 32'h0000_0000);
		$display("bus test done");
	endtask
	////////////////////////////////////////////////////////////////////
	// Counts, verdict and end of run
	task automatic print_verdict;
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_service();
		t_modes();
		t_lock();
		t_ovf();
		t_bus();
		print_verdict();
	end
	// Hang guard, about three times the expected run
	initial begin
		#400000;
		n_fail++;
		print_verdict();
	end
endmodule
